// [hdl/gses_pin_sync.sv]
`timescale 1ns/1ps
module gses_pin_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] pin_in,
  output logic [2:0] level_out,
  output logic [2:0] rise_out,
  output logic [2:0] fall_out
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] last_q;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pin
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
          last_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pin_in[i];
          sync_q[i] <= meta_q[i];
          last_q[i] <= sync_q[i];
        end
      end
      assign level_out[i] = sync_q[i];
      assign rise_out[i] = sync_q[i] & ~last_q[i];
      assign fall_out[i] = ~sync_q[i] & last_q[i];
    end
  endgenerate
endmodule

// [hdl/gses_sequencer.sv]
`timescale 1ns/1ps
`include "gses_defines.svh"
// Notes on behaviour
// - Every frame readout opens with a frame overhead period transferring pixels.
// - Lines follow one by one, each opening with a row overhead period.
// - Each line selects 54 kernels of 24 pixels, 12 per clock edge.
// - A config bit picks internally or externally timed exposure.
// - External timing: exposure follows pins, readout stays internally timed.
// - Pipelined: exposure of next frame runs during readout until stopped.
// - Internal timing: a config bit picks lines or cycles for timers.
// - Line-counted timers change exposure signals only during row overhead.
// - Cycle counts scale by two to a 4-bit prescale; act at expiry.
// - Sync bit defers exposure signal updates to the next row overhead.
// - Same sync bit aligns external exposure pins to row overhead too.
// - Overhead timers count cycles; exposure timers count lines or cycles.
// - Pipelined external: programmed times ignored; pin high ends reset.
// - Pipelined external: pin low samples the image, then readout.
// - Triggered: one image per request; array in reset until pin high.
// - Triggered internal: rising pin starts; timer sets length; fall ignored.
// - Triggered internal: timer expiry starts readout; reset held; new rise.
// - Triggered external: pin low starts frame overhead, then readout.
// - Triggered external: next frame begins when pin rises again.
// - Step count sets samples per pixel reset; one is normal.
// - Multi-sample external: pin protocol unchanged, resets between samples dropped.
// - Monitor outputs stay high during their exposures.
// - Low sequencer reset input resets the sequencer.
module gses_sequencer (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic FIRST_EXPOSURE_PIN_IN,
  input wire logic SECOND_EXPOSURE_PIN_IN,
  input wire logic THIRD_EXPOSURE_PIN_IN,
  output logic PIXEL_RESET_OUT,
  output logic FRAME_OVERHEAD_OUT,
  output logic ROW_OVERHEAD_OUT,
  output logic KERNEL_SELECT_OUT,
  output logic [5:0] KERNEL_INDEX_OUT,
  output logic [10:0] LINE_INDEX_OUT,
  output logic READOUT_BUSY_OUT,
  output logic MONITOR_1_OUT,
  output logic MONITOR_2_OUT,
  output logic MONITOR_3_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [2:0] sequencer_config_a_q;
  logic [7:0] sequencer_config_c_q;
  logic [3:0] sequencer_config_d_q;
  logic [15:0] res_length_q;
  logic [15:0] exposure_duration_q;
  logic [15:0] second_slope_duration_q;
  logic [15:0] third_slope_duration_q;
  logic [15:0] row_overhead_q;
  logic [15:0] frame_overhead_q;
  logic [10:0] line_count_q;
  logic [3:0] samples_per_reset_q;
  logic [31:0] prdata_q;
  gses_pkg::gses_exp_state_t exp_q;
  gses_pkg::gses_exp_state_t exp_d;
  gses_pkg::gses_rd_state_t rd_q;
  logic [15:0] exp_cnt_q;
  logic [15:0] exp_cnt_d;
  logic [15:0] rd_cnt_q;
  logic [5:0] kern_q;
  logic [10:0] line_q;
  logic rd_busy_q;
  logic samp_pend_q;
  logic [3:0] ndr_cnt_q;
  logic [14:0] div_cnt_q;
  logic pix_reset_q;
  logic [2:0] mon_q;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic enable;
  logic slave;
  logic trig;
  logic lines_mode;
  logic sync_rot;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_val;
  logic [14:0] div_lim;
  logic div_tick;
  logic line_tick;
  logic tick;
  logic exp_smp;
  logic ndr_last;
  logic upd_ok;
  logic fot_enter;
  logic samp_evt;
  logic pix_reset_d;
  logic [2:0] mon_d;

  assign enable = sequencer_config_a_q[`GSES_A_ENABLE];
  assign slave = sequencer_config_a_q[`GSES_A_SLAVE];
  assign trig = sequencer_config_a_q[`GSES_A_TRIG];
  assign lines_mode = sequencer_config_c_q[`GSES_C_LINES];
  assign sync_rot = sequencer_config_c_q[`GSES_C_SYNC];

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign setup_ph = PSEL_IN & ~PENABLE_IN;
  assign access_ph = PSEL_IN & PENABLE_IN;
  assign wr_en = access_ph & PWRITE_IN & mapped;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access_ph & ~mapped;
  assign PRDATA_OUT = prdata_q;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0;
    case (PADDR_IN)
      `GSES_OFF_CFG_A: rd_val = {29'h0, sequencer_config_a_q};
      `GSES_OFF_CFG_C: rd_val = {24'h0, sequencer_config_c_q};
      `GSES_OFF_CFG_D: rd_val = {28'h0, sequencer_config_d_q};
      `GSES_OFF_RES_LEN: rd_val = {16'h0, res_length_q};
      `GSES_OFF_TINT: rd_val = {16'h0, exposure_duration_q};
      `GSES_OFF_TINT_DS: rd_val = {16'h0, second_slope_duration_q};
      `GSES_OFF_TINT_TS: rd_val = {16'h0, third_slope_duration_q};
      `GSES_OFF_ROT: rd_val = {16'h0, row_overhead_q};
      `GSES_OFF_FOT: rd_val = {16'h0, frame_overhead_q};
      `GSES_OFF_LINES: rd_val = {21'h0, line_count_q};
      `GSES_OFF_SAMPLES: rd_val = {28'h0, samples_per_reset_q};
      `GSES_OFF_STATUS: rd_val = {11'h0, ndr_cnt_q, line_q, rd_busy_q, samp_pend_q, rd_q, exp_q};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      prdata_q <= 32'h0;
    end else if (setup_ph && !PWRITE_IN) begin
      prdata_q <= rd_val;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sequencer_config_a_q <= `GSES_RST_CFG_A;
      sequencer_config_c_q <= `GSES_RST_CFG_C;
      sequencer_config_d_q <= `GSES_RST_CFG_D;
      res_length_q <= `GSES_RST_RES_LEN;
      exposure_duration_q <= `GSES_RST_TINT;
      second_slope_duration_q <= `GSES_RST_TINT_DS;
      third_slope_duration_q <= `GSES_RST_TINT_TS;
      row_overhead_q <= `GSES_RST_ROT;
      frame_overhead_q <= `GSES_RST_FOT;
      line_count_q <= `GSES_RST_LINES;
      samples_per_reset_q <= `GSES_RST_SAMPLES;
    end else if (wr_en) begin
      case (PADDR_IN)
        `GSES_OFF_CFG_A: sequencer_config_a_q <= PWDATA_IN[2:0];
        `GSES_OFF_CFG_C: sequencer_config_c_q <= PWDATA_IN[7:0] & `GSES_C_MASK;
        `GSES_OFF_CFG_D: sequencer_config_d_q <= PWDATA_IN[3:0];
        `GSES_OFF_RES_LEN: res_length_q <= PWDATA_IN[15:0];
        `GSES_OFF_TINT: exposure_duration_q <= PWDATA_IN[15:0];
        `GSES_OFF_TINT_DS: second_slope_duration_q <= PWDATA_IN[15:0];
        `GSES_OFF_TINT_TS: third_slope_duration_q <= PWDATA_IN[15:0];
        `GSES_OFF_ROT: row_overhead_q <= PWDATA_IN[15:0];
        `GSES_OFF_FOT: frame_overhead_q <= PWDATA_IN[15:0];
        `GSES_OFF_LINES: line_count_q <= PWDATA_IN[10:0];
        `GSES_OFF_SAMPLES: samples_per_reset_q <= PWDATA_IN[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Exposure pin synchronisers
  // ----------------------------------------
  gses_pin_sync u_pin_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .pin_in({THIRD_EXPOSURE_PIN_IN, SECOND_EXPOSURE_PIN_IN, FIRST_EXPOSURE_PIN_IN}),
    .level_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // ----------------------------------------
  // Readout: frame overhead, row overhead, kernels
  // ----------------------------------------
  assign fot_enter = (rd_q == gses_pkg::GSES_RD_KERN) && (kern_q == `GSES_LAST_KERNEL)
    && samp_pend_q;
  assign line_tick = (rd_q == gses_pkg::GSES_RD_ROT) && (rd_cnt_q == 16'h0);

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_q <= gses_pkg::GSES_RD_ROT;
      rd_cnt_q <= 16'h0;
      kern_q <= 6'h0;
      line_q <= 11'h0;
      rd_busy_q <= 1'b0;
    end else begin
      case (rd_q)
        gses_pkg::GSES_RD_ROT: begin
          if ({1'b0, rd_cnt_q} + 17'h1 >= {1'b0, row_overhead_q}) begin
            rd_q <= gses_pkg::GSES_RD_KERN;
            rd_cnt_q <= 16'h0;
            kern_q <= 6'h0;
          end else begin
            rd_cnt_q <= rd_cnt_q + 16'h1;
          end
        end
        gses_pkg::GSES_RD_KERN: begin
          if (kern_q != `GSES_LAST_KERNEL) begin
            kern_q <= kern_q + 6'h1;
          end else if (samp_pend_q) begin
            rd_q <= gses_pkg::GSES_RD_FOT;
            rd_busy_q <= 1'b1;
            line_q <= 11'h0;
          end else begin
            rd_q <= gses_pkg::GSES_RD_ROT;
            if (rd_busy_q && ({1'b0, line_q} + 12'h1 >= {1'b0, line_count_q})) begin
              rd_busy_q <= 1'b0;
              line_q <= 11'h0;
            end else if (rd_busy_q) begin
              line_q <= line_q + 11'h1;
            end
          end
        end
        gses_pkg::GSES_RD_FOT: begin
          if ({1'b0, rd_cnt_q} + 17'h1 >= {1'b0, frame_overhead_q}) begin
            rd_q <= gses_pkg::GSES_RD_ROT;
            rd_cnt_q <= 16'h0;
          end else begin
            rd_cnt_q <= rd_cnt_q + 16'h1;
          end
        end
        default: rd_q <= gses_pkg::GSES_RD_ROT;
      endcase
    end
  end

  assign FRAME_OVERHEAD_OUT = (rd_q == gses_pkg::GSES_RD_FOT);
  assign ROW_OVERHEAD_OUT = (rd_q == gses_pkg::GSES_RD_ROT);
  assign KERNEL_SELECT_OUT = (rd_q == gses_pkg::GSES_RD_KERN) && rd_busy_q;
  assign KERNEL_INDEX_OUT = kern_q;
  assign LINE_INDEX_OUT = line_q;
  assign READOUT_BUSY_OUT = rd_busy_q;

  chk_fot_after_line: assert property ($rose(FRAME_OVERHEAD_OUT) |-> $past(fot_enter))
    else $error("frame overhead began outside a line end with a pending sample");
  chk_kern_after_rot: assert property (
    (rd_q == gses_pkg::GSES_RD_KERN && $past(rd_q) != gses_pkg::GSES_RD_KERN)
    |-> $past(rd_q) == gses_pkg::GSES_RD_ROT)
    else $error("kernel phase not preceded by row overhead");
  chk_kern_count: assert property (
    (rd_q == gses_pkg::GSES_RD_KERN && kern_q == 6'h0)
    |-> ##53 (rd_q == gses_pkg::GSES_RD_KERN && kern_q == `GSES_LAST_KERNEL))
    else $error("line did not hold 54 kernels");

  // ----------------------------------------
  // Timer base: lines or prescaled cycles
  // ----------------------------------------
  assign div_lim = 15'((16'h1 << sequencer_config_d_q) - 16'h1);
  assign div_tick = (div_cnt_q == div_lim);
  assign tick = lines_mode ? line_tick : div_tick;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_cnt_q <= 15'h0;
    end else if (div_tick || div_cnt_q > div_lim) begin
      div_cnt_q <= 15'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 15'h1;
    end
  end

  sequence s_presc2_gap;
    (sequencer_config_d_q == 4'h2 && !div_tick)[*3] ##1 (sequencer_config_d_q == 4'h2);
  endsequence
  chk_presc_period: assert property (
    (sequencer_config_d_q == 4'h2 && div_tick) ##1 s_presc2_gap |-> div_tick)
    else $error("prescaled tick period is not four cycles");

  // ----------------------------------------
  // Exposure control
  // ----------------------------------------
  assign ndr_last = ({1'b0, ndr_cnt_q} + 5'h1) >= {1'b0, samples_per_reset_q};

  always_comb begin
    exp_d = exp_q;
    exp_cnt_d = exp_cnt_q;
    exp_smp = 1'b0;
    case (exp_q)
      gses_pkg::GSES_EX_IDLE: begin
        if (!trig && !slave) begin
          exp_d = gses_pkg::GSES_EX_RESET;
          exp_cnt_d = 16'h0;
        end else if (pin_rise[0] && (!trig || !(rd_busy_q || samp_pend_q))) begin
          exp_d = gses_pkg::GSES_EX_EXPOSE;
          exp_cnt_d = 16'h0;
        end
      end
      gses_pkg::GSES_EX_RESET: begin
        if (tick && ({1'b0, exp_cnt_q} + 17'h1 >= {1'b0, res_length_q})) begin
          exp_d = gses_pkg::GSES_EX_EXPOSE;
          exp_cnt_d = 16'h0;
        end else if (tick) begin
          exp_cnt_d = exp_cnt_q + 16'h1;
        end
      end
      gses_pkg::GSES_EX_EXPOSE: begin
        if (slave) begin
          if (pin_fall[0]) begin
            exp_smp = 1'b1;
            exp_d = gses_pkg::GSES_EX_IDLE;
          end
        end else if (tick && ({1'b0, exp_cnt_q} + 17'h1 >= {1'b0, exposure_duration_q})) begin
          exp_smp = 1'b1;
          exp_cnt_d = 16'h0;
          if (trig) begin
            exp_d = gses_pkg::GSES_EX_IDLE;
          end else if (ndr_last) begin
            exp_d = gses_pkg::GSES_EX_RESET;
          end else begin
            exp_d = gses_pkg::GSES_EX_EXPOSE;
          end
        end else if (tick) begin
          exp_cnt_d = exp_cnt_q + 16'h1;
        end
      end
      default: exp_d = gses_pkg::GSES_EX_IDLE;
    endcase
    if (!enable) begin
      exp_d = gses_pkg::GSES_EX_IDLE;
      exp_smp = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      exp_q <= gses_pkg::GSES_EX_IDLE;
      exp_cnt_q <= 16'h0;
    end else begin
      exp_q <= exp_d;
      exp_cnt_q <= exp_cnt_d;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ndr_cnt_q <= 4'h0;
    end else if (!enable) begin
      ndr_cnt_q <= 4'h0;
    end else if (exp_smp) begin
      ndr_cnt_q <= ndr_last ? 4'h0 : ndr_cnt_q + 4'h1;
    end
  end

  chk_slave_pin_only: assert property (
    (enable && slave && exp_q == gses_pkg::GSES_EX_EXPOSE && !pin_fall[0])
    |=> exp_q == gses_pkg::GSES_EX_EXPOSE)
    else $error("external exposure ended without the pin falling");
  chk_trig_one_shot: assert property (
    (enable && trig && exp_q == gses_pkg::GSES_EX_IDLE && !pin_rise[0])
    |=> exp_q == gses_pkg::GSES_EX_IDLE)
    else $error("triggered exposure started without a rising pin edge");
  chk_pipe_continues: assert property (
    (enable && !trig && !slave && exp_smp) |=> exp_q != gses_pkg::GSES_EX_IDLE)
    else $error("pipelined exposure stopped after a sample");

  // ----------------------------------------
  // Applied pixel controls and monitors
  // ----------------------------------------
  assign pix_reset_d = (exp_q != gses_pkg::GSES_EX_EXPOSE) && (ndr_cnt_q == 4'h0);
  assign mon_d[0] = (exp_q == gses_pkg::GSES_EX_EXPOSE);
  assign mon_d[1] = mon_d[0] && (slave ? pin_lvl[1] :
    ({1'b0, exp_cnt_q} + {1'b0, second_slope_duration_q} >= {1'b0, exposure_duration_q}));
  assign mon_d[2] = mon_d[0] && (slave ? pin_lvl[2] :
    ({1'b0, exp_cnt_q} + {1'b0, third_slope_duration_q} >= {1'b0, exposure_duration_q}));
  // Deferred updates land only inside a row overhead period
  assign upd_ok = !(sync_rot || (lines_mode && !slave))
    || (rd_q == gses_pkg::GSES_RD_ROT);
  assign samp_evt = mon_q[0] && upd_ok && !mon_d[0];

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pix_reset_q <= 1'b1;
      mon_q <= 3'h0;
    end else if (upd_ok) begin
      pix_reset_q <= pix_reset_d;
      mon_q <= mon_d;
    end
  end

  // Sample request set wins over its clear at frame overhead entry
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      samp_pend_q <= 1'b0;
    end else begin
      samp_pend_q <= samp_evt || (samp_pend_q && !fot_enter);
    end
  end

  assign PIXEL_RESET_OUT = pix_reset_q;
  assign MONITOR_1_OUT = mon_q[0];
  assign MONITOR_2_OUT = mon_q[1];
  assign MONITOR_3_OUT = mon_q[2];

  chk_sync_defer: assert property (
    (sync_rot && rd_q != gses_pkg::GSES_RD_ROT) |=> $stable(pix_reset_q) && $stable(mon_q))
    else $error("exposure controls changed outside row overhead");
  chk_lines_in_rot: assert property (
    (lines_mode && !slave && rd_q != gses_pkg::GSES_RD_ROT) |=> $stable(mon_q[0]))
    else $error("line-counted exposure changed outside row overhead");
  chk_sample_pending: assert property (samp_evt |=> samp_pend_q)
    else $error("exposure end did not request a frame readout");
  chk_monitor_expose: assert property (
    $rose(MONITOR_1_OUT) |-> $past(exp_q) == gses_pkg::GSES_EX_EXPOSE)
    else $error("exposure monitor rose outside exposure");
  chk_ndr_no_reset: assert property (
    (ndr_cnt_q != 4'h0 && upd_ok) |=> !PIXEL_RESET_OUT)
    else $error("pixel reset issued between multi-sample reads");
endmodule

// [inc/gses_defines.svh]
`ifndef GSES_DEFINES_SVH
`define GSES_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GSES_OFF_CFG_A 8'h00
`define GSES_OFF_CFG_C 8'h04
`define GSES_OFF_CFG_D 8'h08
`define GSES_OFF_RES_LEN 8'h0c
`define GSES_OFF_TINT 8'h10
`define GSES_OFF_TINT_DS 8'h14
`define GSES_OFF_TINT_TS 8'h18
`define GSES_OFF_ROT 8'h1c
`define GSES_OFF_FOT 8'h20
`define GSES_OFF_LINES 8'h24
`define GSES_OFF_SAMPLES 8'h28
`define GSES_OFF_STATUS 8'h2c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GSES_A_ENABLE 0
`define GSES_A_SLAVE 1
`define GSES_A_TRIG 2
`define GSES_C_LINES 6
`define GSES_C_SYNC 7
`define GSES_C_MASK 8'hc0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GSES_RST_CFG_A 3'h0
`define GSES_RST_CFG_C 8'h00
`define GSES_RST_CFG_D 4'h0
`define GSES_RST_RES_LEN 16'h0010
`define GSES_RST_TINT 16'h0040
`define GSES_RST_TINT_DS 16'h0000
`define GSES_RST_TINT_TS 16'h0000
`define GSES_RST_ROT 16'h0009
`define GSES_RST_FOT 16'h013b
`define GSES_RST_LINES 11'h400
`define GSES_RST_SAMPLES 4'h1
// ----------------------------------------
// Line geometry: 54 kernels of 24 pixels
// ----------------------------------------
`define GSES_LAST_KERNEL 6'h35
`endif

// [inc/gses_pkg.sv]
package gses_pkg;
  typedef enum logic [1:0] {
    GSES_EX_IDLE = 2'b00,
    GSES_EX_RESET = 2'b01,
    GSES_EX_EXPOSE = 2'b11
  } gses_exp_state_t;

  typedef enum logic [1:0] {
    GSES_RD_ROT = 2'b00,
    GSES_RD_KERN = 2'b01,
    GSES_RD_FOT = 2'b11
  } gses_rd_state_t;
endpackage

// [tb/gses_ctrl_model.sv]
`timescale 1ns/1ps
module gses_ctrl_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic row_overhead_in,
  input wire logic free_in,
  input wire logic [2:0] want_in,
  output logic [2:0] pin_out
);
  // ----------------------------------------
  // Exposure pins, moved inside row overhead, or at any time while free_in is high
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= 3'h0;
    end else if (row_overhead_in || free_in) begin
      pin_out <= want_in;
    end
  end
endmodule

// [tb/gses_sequencer_test.sv]
`timescale 1ns/1ps
`include "gses_defines.svh"
module gses_sequencer_test;
  localparam int FOT = 0, BSY = 1, PIX = 2, MON = 3, ROW = 4, KSEL = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic free = 1'b0;
  logic watch = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [2:0] want = 3'h0;
  logic [1:0] rot_h = 2'h0;
  logic mon1_q = 1'b0;
  logic [31:0] prd, rd;
  logic [2:0] pins;
  logic [5:0] kidx;
  logic [10:0] lidx;
  logic rdy, serr, err, pix, fov, rov, ksel, busy, mon1, mon2, mon3;
  int fails = 0;
  int n_tests = 0;
  int rises = 0;
  int n;

  gses_sequencer u_dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
    .PSLVERR_OUT(serr), .FIRST_EXPOSURE_PIN_IN(pins[0]), .SECOND_EXPOSURE_PIN_IN(pins[1]),
    .THIRD_EXPOSURE_PIN_IN(pins[2]), .PIXEL_RESET_OUT(pix), .FRAME_OVERHEAD_OUT(fov),
    .ROW_OVERHEAD_OUT(rov), .KERNEL_SELECT_OUT(ksel), .KERNEL_INDEX_OUT(kidx),
    .LINE_INDEX_OUT(lidx), .READOUT_BUSY_OUT(busy), .MONITOR_1_OUT(mon1),
    .MONITOR_2_OUT(mon2), .MONITOR_3_OUT(mon3)
  );
  gses_ctrl_model u_ctrl (
    .clk_in(clk), .rst_n_in(rst_n), .row_overhead_in(rov), .free_in(free), .want_in(want),
    .pin_out(pins)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  function automatic logic sig(input int k);
    logic [5:0] v;
    v = {ksel, rov, mon1, pix, busy, fov};
    return v[k];
  endfunction
  // Bounded wait for a level, then judged
  task automatic await(input int k, input logic v, input int max);
    int i;
    i = 0;
    while (sig(k) !== v && i < max) begin
      @(posedge clk);
      i++;
    end
    check(32'(sig(k)), 32'(v));
  endtask
  task automatic span(input int k, output int m);
    m = 0;
    while (sig(k) === 1'b1 && m < 1000) begin
      @(posedge clk);
      m++;
    end
  endtask
  task automatic setup(input logic [2:0] mode, input logic [7:0] c);
    await(BSY, 1'b0, 400);
    apb(1'b1, `GSES_OFF_CFG_A, 32'h0);
    apb(1'b1, `GSES_OFF_CFG_C, {24'h0, c});
    apb(1'b1, `GSES_OFF_CFG_A, {29'h0, mode});
  endtask

  // Monitor edges must land next to a row overhead
  always @(posedge clk) begin
    if (watch && mon1 !== mon1_q) begin
      check(32'(rov | rot_h[0] | rot_h[1]), 32'h1);
      rises += int'(mon1);
    end
    mon1_q <= mon1;
    rot_h <= {rot_h[0], rov};
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(32'({pix, rov, busy, mon1}), 32'hc);
    rst_n <= 1'b1;
    rchk(`GSES_OFF_CFG_A, 32'h0);
    rchk(`GSES_OFF_TINT, 32'h40);
    rchk(`GSES_OFF_FOT, 32'h13b);
    rchk(`GSES_OFF_SAMPLES, 32'h1);
    rchk(8'h30, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, `GSES_OFF_CFG_C, 32'hff);
    rchk(`GSES_OFF_CFG_C, 32'hc0);
    apb(1'b1, `GSES_OFF_ROT, 32'h3);
    apb(1'b1, `GSES_OFF_FOT, 32'h4);
    apb(1'b1, `GSES_OFF_LINES, 32'h2);
  endtask
  task automatic t_geometry();
    setup(3'h3, 8'h00);
    want <= 3'h1;
    await(MON, 1'b1, 200);
    check(32'(pix), 32'h0);
    want <= 3'h0;
    await(MON, 1'b0, 200);
    await(FOT, 1'b1, 200);
    span(FOT, n);
    check(32'(n), 32'h4);
    span(ROW, n);
    check(32'(n), 32'h3);
    span(KSEL, n);
    check(32'(n), 32'h36);
    await(KSEL, 1'b1, 20);
    check(32'(kidx), 32'h0);
    check(32'(lidx), 32'h1);
  endtask
  task automatic t_trig_master();
    apb(1'b1, `GSES_OFF_CFG_D, 32'h2);
    apb(1'b1, `GSES_OFF_TINT, 32'ha);
    apb(1'b1, `GSES_OFF_TINT_DS, 32'h3);
    setup(3'h5, 8'h00);
    repeat (150) @(posedge clk);
    check(32'({pix, busy}), 32'h2);
    want <= 3'h1;
    await(MON, 1'b1, 200);
    check(32'({mon2, mon3}), 32'h0);
    want <= 3'h0;
    span(MON, n);
    check(32'(n >= 36 && n <= 42), 32'h1);
    await(FOT, 1'b1, 80);
    check(32'(pix), 32'h1);
    await(BSY, 1'b0, 200);
    repeat (150) @(posedge clk);
    check(32'({mon1, busy}), 32'h0);
  endtask
  task automatic t_trig_slave();
    setup(3'h7, 8'h00);
    want <= 3'h1;
    await(PIX, 1'b0, 200);
    repeat (150) @(posedge clk);
    check(32'({fov, busy, pix}), 32'h0);
    want <= 3'h0;
    await(FOT, 1'b1, 200);
    span(FOT, n);
    check(32'(pix), 32'h1);
    await(BSY, 1'b0, 200);
    want <= 3'h1;
    await(MON, 1'b1, 200);
    want <= 3'h0;
  endtask
  task automatic t_sync();
    free <= 1'b1;
    setup(3'h3, 8'h80);
    watch <= 1'b1;
    repeat (3) begin
      await(ROW, 1'b1, 80);
      await(ROW, 1'b0, 80);
      repeat (20) @(posedge clk);
      want <= ~want;
      repeat (150) @(posedge clk);
    end
    check(32'({mon1, mon2, mon3}), 32'h7);
    watch <= 1'b0;
    want <= 3'h0;
    free <= 1'b0;
    apb(1'b1, `GSES_OFF_RES_LEN, 32'h1);
    apb(1'b1, `GSES_OFF_TINT, 32'h2);
    setup(3'h1, 8'h40);
    rises = 0;
    watch <= 1'b1;
    repeat (800) @(posedge clk);
    check(32'(rises >= 2), 32'h1);
    watch <= 1'b0;
  endtask
  task automatic t_ndr();
    apb(1'b1, `GSES_OFF_SAMPLES, 32'h2);
    setup(3'h3, 8'h00);
    want <= 3'h1;
    await(MON, 1'b1, 200);
    want <= 3'h0;
    await(FOT, 1'b1, 200);
    check(32'(pix), 32'h0);
  endtask

  task automatic print_verdict();
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    t_reset();
    t_geometry();
    t_trig_master();
    t_trig_slave();
    t_sync();
    t_ndr();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
